/* File: core/spvl_top.sv */
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/100ps
module spvl_top #(
    parameter int NUM_IRQ = 32,
    parameter int PRIO_BITS = 8,
    parameter int MIN_BP = 0
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire spvl_pkg::spvl_apb_req_t apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cand_valid,
    input wire logic [7:0] cand_id,
    input wire logic [7:0] running_prio,
    output logic preempt_req
);
    generate
        if (NUM_IRQ < 1 || NUM_IRQ > 32) begin : g_bad_num_irq
            $error("spvl_top: NUM_IRQ must lie in 1 to 32.");
        end
        if (PRIO_BITS < 5 || PRIO_BITS > 8) begin : g_bad_prio_bits
            $error("spvl_top: PRIO_BITS must lie in 5 to 8.");
        end
    endgenerate

    // Valid priority bits: the top PRIO_BITS of the 8-bit field.
    localparam logic [7:0] P_MASK = 8'(16'hFF00 >> PRIO_BITS);
    localparam logic [7:0] NUM_IRQ_V = 8'(NUM_IRQ);

    // Register state.
    logic [7:0] prio [NUM_IRQ];
    logic [NUM_IRQ-1:0] irq_sec;
    logic [7:0] priority_mask_reg;
    logic [7:0] running_priority_reg;
    logic [2:0] bpr_s;
    logic [2:0] bpr_ns;
    logic shared_binary_point_sel;

    // Decoded request.
    spvl_pkg::spvl_sel_t sel;
    logic ns_acc;
    logic [7:0] idx;
    logic idx_ok;
    logic [7:0] wbyte;
    logic wr_take;
    logic next_err;
    logic [31:0] next_prdata;

    // Request attributes.
    always_comb begin
        ns_acc = apb_req.pprot[spvl_pkg::PROT_NS_BIT];
        idx = apb_req.paddr[spvl_pkg::PRIO_INDEX_LSB +: spvl_pkg::PRIO_INDEX_W];
        idx_ok = idx < NUM_IRQ_V;
        wbyte = apb_req.pwdata[7:0];
    end

    // Address decode.
    always_comb begin
        sel = spvl_pkg::SPVL_SEL_NONE;
        if (apb_req.paddr[11:10] == spvl_pkg::PRIO_REGION) begin
            if (idx_ok && apb_req.paddr[1:0] == 2'h0) begin
                sel = spvl_pkg::SPVL_SEL_PRIO;
            end
        end else begin
            unique case (apb_req.paddr)
                spvl_pkg::OFF_CTRL: begin
                    sel = spvl_pkg::SPVL_SEL_CTRL;
                end
                spvl_pkg::OFF_PMR: begin
                    sel = spvl_pkg::SPVL_SEL_PMR;
                end
                spvl_pkg::OFF_BPR: begin
                    sel = spvl_pkg::SPVL_SEL_BPR;
                end
                spvl_pkg::OFF_RPR: begin
                    sel = spvl_pkg::SPVL_SEL_RPR;
                end
                spvl_pkg::OFF_BPR_ALIAS: begin
                    sel = spvl_pkg::SPVL_SEL_BPR_ALIAS;
                end
                spvl_pkg::OFF_SEC_CFG: begin
                    sel = spvl_pkg::SPVL_SEL_SEC_CFG;
                end
                default: begin
                    sel = spvl_pkg::SPVL_SEL_NONE;
                end
            endcase
        end
    end

    // The Secure-only alias and security configuration answer Non-secure accesses with an error; CTRL reads zero and ignores them.
    always_comb begin
        next_err = 1'b0;
        if (sel == spvl_pkg::SPVL_SEL_NONE) begin
            next_err = 1'b1;
        end else if (ns_acc && (sel == spvl_pkg::SPVL_SEL_BPR_ALIAS || sel == spvl_pkg::SPVL_SEL_SEC_CFG)) begin
            next_err = 1'b1;
        end
    end

    // Read data, in the view that the access attribute selects.
    always_comb begin
        next_prdata = '0;
        unique case (sel)
            spvl_pkg::SPVL_SEL_PRIO: begin
                if (!ns_acc) begin
                    next_prdata[7:0] = prio[idx[4:0]];
                end else if (irq_sec[idx[4:0]]) begin
                    next_prdata[7:0] = 8'h00;
                end else begin
                    next_prdata[7:0] = {prio[idx[4:0]][6:0], 1'b0};
                end
            end
            spvl_pkg::SPVL_SEL_PMR: begin
                if (!ns_acc) begin
                    next_prdata[7:0] = priority_mask_reg;
                end else if (!priority_mask_reg[spvl_pkg::PRIO_TOP_BIT]) begin
                    next_prdata[7:0] = 8'h00;
                end else begin
                    next_prdata[7:0] = {priority_mask_reg[6:0], 1'b0};
                end
            end
            spvl_pkg::SPVL_SEL_RPR: begin
                if (!ns_acc) begin
                    next_prdata[7:0] = running_priority_reg;
                end else if (!running_priority_reg[spvl_pkg::PRIO_TOP_BIT]) begin
                    next_prdata[7:0] = 8'h00;
                end else begin
                    next_prdata[7:0] = {running_priority_reg[6:0], 1'b0};
                end
            end
            spvl_pkg::SPVL_SEL_BPR: begin
                next_prdata[2:0] = ns_acc ? bpr_ns : bpr_s;
            end
            spvl_pkg::SPVL_SEL_BPR_ALIAS: begin
                next_prdata[2:0] = ns_acc ? 3'h0 : bpr_ns;
            end
            spvl_pkg::SPVL_SEL_CTRL: begin
                next_prdata[spvl_pkg::CTRL_SBPS_BIT] = ns_acc ? 1'b0 : shared_binary_point_sel;
            end
            spvl_pkg::SPVL_SEL_SEC_CFG: begin
                next_prdata[NUM_IRQ-1:0] = ns_acc ? '0 : irq_sec;
            end
            default: begin
                next_prdata = '0;
            end
        endcase
    end

    // The access phase answers one cycle after it starts.
    always_ff @(posedge clock) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else if (ce) begin
            pready <= apb_req.psel && apb_req.penable && !pready;
            if (apb_req.psel && apb_req.penable && !pready) begin
                pslverr <= next_err;
                prdata <= apb_req.pwrite ? '0 : next_prdata;
            end else begin
                pslverr <= 1'b0;
                prdata <= '0;
            end
        end
    end

    // A write takes effect only at the completing edge and only without error.
    always_comb begin
        wr_take = ce && apb_req.psel && apb_req.penable && pready && apb_req.pwrite && !pslverr;
    end

    // Priority fields.
    always_ff @(posedge clock) begin
        if (rst) begin
            for (int i = 0; i < NUM_IRQ; i++) begin
                prio[i] <= spvl_pkg::PRIO_RST;
            end
        end else if (wr_take && sel == spvl_pkg::SPVL_SEL_PRIO) begin
            if (!ns_acc) begin
                prio[idx[4:0]] <= wbyte & P_MASK;
            end else if (!irq_sec[idx[4:0]]) begin
                prio[idx[4:0]] <= {1'b1, wbyte[7:1]} & P_MASK;
            end
        end
    end

    // Interrupt security configuration.
    always_ff @(posedge clock) begin
        if (rst) begin
            irq_sec <= '0;
        end else if (wr_take && sel == spvl_pkg::SPVL_SEL_SEC_CFG) begin
            irq_sec <= apb_req.pwdata[NUM_IRQ-1:0];
        end
    end

    // Priority mask register.
    always_ff @(posedge clock) begin
        if (rst) begin
            priority_mask_reg <= spvl_pkg::PMR_RST;
        end else if (wr_take && sel == spvl_pkg::SPVL_SEL_PMR) begin
            if (!ns_acc) begin
                priority_mask_reg <= wbyte & P_MASK;
            end else if (priority_mask_reg[spvl_pkg::PRIO_TOP_BIT]) begin
                priority_mask_reg <= {1'b1, wbyte[7:1]} & P_MASK;
            end
        end
    end

    // Running priority follows the acknowledge logic outside.
    always_ff @(posedge clock) begin
        if (rst) begin
            running_priority_reg <= spvl_pkg::RPR_IDLE;
        end else if (ce) begin
            running_priority_reg <= running_prio;
        end
    end

    // Binary point copies.
    always_ff @(posedge clock) begin
        if (rst) begin
            bpr_s <= spvl_pkg::BPR_S_RST;
        end else if (wr_take && sel == spvl_pkg::SPVL_SEL_BPR && !ns_acc) begin
            bpr_s <= apb_req.pwdata[2:0];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            bpr_ns <= spvl_pkg::BPR_NS_RST;
        end else if (wr_take && sel == spvl_pkg::SPVL_SEL_BPR && ns_acc) begin
            bpr_ns <= apb_req.pwdata[2:0];
        end else if (wr_take && sel == spvl_pkg::SPVL_SEL_BPR_ALIAS) begin
            bpr_ns <= apb_req.pwdata[2:0];
        end
    end

    // Interface control.
    always_ff @(posedge clock) begin
        if (rst) begin
            shared_binary_point_sel <= spvl_pkg::CTRL_SBPS_RST;
        end else if (wr_take && sel == spvl_pkg::SPVL_SEL_CTRL && !ns_acc) begin
            shared_binary_point_sel <= apb_req.pwdata[spvl_pkg::CTRL_SBPS_BIT];
        end
    end

    // Preemption check for the candidate interrupt.
    logic cand_ok;
    logic cand_sec;
    logic [7:0] cand_prio;
    logic [2:0] sel_bp;
    logic [7:0] grp_mask;
    logic next_preempt;

    always_comb begin
        cand_ok = cand_valid && (cand_id < NUM_IRQ_V);
        cand_sec = cand_ok ? irq_sec[cand_id[4:0]] : 1'b0;
        cand_prio = cand_ok ? prio[cand_id[4:0]] : 8'hFF;
        if (cand_sec) begin
            sel_bp = bpr_s;
        end else if (shared_binary_point_sel) begin
            sel_bp = bpr_s;
        end else begin
            sel_bp = bpr_ns;
        end
    end

    spvl_group_mask #(
        .MIN_BP(MIN_BP)
    ) u_group_mask (
        .bp(sel_bp),
        .ns_int(!cand_sec),
        .mask(grp_mask)
    );

    // Lower number wins both against the mask and against the running group.
    always_comb begin
        next_preempt = cand_ok
            && (cand_prio < priority_mask_reg)
            && ((cand_prio & grp_mask) < (running_priority_reg & grp_mask));
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            preempt_req <= 1'b0;
        end else if (ce) begin
            preempt_req <= next_preempt;
        end
    end
endmodule

/* File: core/spvl_pkg.sv */
package spvl_pkg;

    // Register bus geometry.
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // Byte offsets of the registers.
    localparam logic [11:0] OFF_CTRL = 12'h100;
    localparam logic [11:0] OFF_PMR = 12'h104;
    localparam logic [11:0] OFF_BPR = 12'h108;
    localparam logic [11:0] OFF_RPR = 12'h114;
    localparam logic [11:0] OFF_BPR_ALIAS = 12'h11C;
    localparam logic [11:0] OFF_SEC_CFG = 12'h180;
    localparam logic [11:0] OFF_PRIO_BASE = 12'h400;

    // Priority fields occupy one word each from the base upward.
    localparam logic [1:0] PRIO_REGION = 2'h1;
    localparam int PRIO_REGION_LSB = 10;
    localparam int PRIO_INDEX_LSB = 2;
    localparam int PRIO_INDEX_W = 8;

    // Field positions.
    localparam int CTRL_SBPS_BIT = 0;
    localparam int PROT_NS_BIT = 1;
    localparam int PRIO_TOP_BIT = 7;
    localparam int BP_W = 3;

    // Reset values.
    localparam logic [7:0] PRIO_RST = 8'h00;
    localparam logic [7:0] PMR_RST = 8'h00;
    localparam logic [7:0] RPR_IDLE = 8'hFF;
    localparam logic [2:0] BPR_S_RST = 3'h2;
    localparam logic [2:0] BPR_NS_RST = 3'h3;
    localparam logic CTRL_SBPS_RST = 1'b0;

    // APB request as seen by the slave.
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [2:0] pprot;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } spvl_apb_req_t;

    // Which register a bus address selects.
    typedef enum {
        SPVL_SEL_NONE,
        SPVL_SEL_CTRL,
        SPVL_SEL_PMR,
        SPVL_SEL_BPR,
        SPVL_SEL_RPR,
        SPVL_SEL_BPR_ALIAS,
        SPVL_SEL_SEC_CFG,
        SPVL_SEL_PRIO
    } spvl_sel_t;

endpackage

/* File: core/spvl_group_mask.sv */
`timescale 1ns/100ps
// Forms the group priority mask for one binary point value.
module spvl_group_mask #(
    parameter int MIN_BP = 0
) (
    input wire logic [2:0] bp,
    input wire logic ns_int,
    output logic [7:0] mask
);
    generate
        if (MIN_BP < 0 || MIN_BP > 3) begin : g_bad_min_bp
            $error("spvl_group_mask: MIN_BP must lie in 0 to 3.");
        end
    endgenerate

    localparam logic [3:0] MIN_BP_V = 4'(MIN_BP);

    logic [3:0] n_sat;
    logic [3:0] n_eff;

    always_comb begin
        n_sat = ({1'b0, bp} < MIN_BP_V) ? MIN_BP_V : {1'b0, bp};
        n_eff = ns_int ? n_sat : 4'(n_sat + 4'h1);
        mask = 8'hFF << n_eff;
    end
endmodule

/* File: tb/spvl_top_checker.sv */
`timescale 1ns/100ps
module spvl_top_checker #(
    parameter int NUM_IRQ = 32,
    parameter int PRIO_BITS = 8
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire spvl_pkg::spvl_apb_req_t apb_req,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic cand_valid,
    input wire logic [7:0] cand_id,
    input wire logic [7:0] running_prio,
    input wire logic preempt_req
);
    localparam logic [31:0] S_OK = 32'(8'hFF << (8 - PRIO_BITS));
    localparam logic [31:0] NS_OK = 32'(8'hFF << (9 - PRIO_BITS));
    default clocking @(posedge clock); endclocking
    default disable iff (rst || !ce);
    wire logic ns = apb_req.pprot[1];
    wire logic rd = pready && !apb_req.pwrite;
    wire logic swr = pready && !pslverr && apb_req.pwrite && !ns;
    wire logic prio_hit = apb_req.paddr[11:10] == spvl_pkg::PRIO_REGION;
    wire logic [7:0] idx = apb_req.paddr[9:2];
    logic pmr_b7;
    logic [31:0] sec_map;
    logic [2:0] rp7_h;
    logic [2:0] rpz_h;
    // Shadows of what only Secure writes can set, for the hiding checks.
    always_ff @(posedge clock) begin
        if (rst) begin
            pmr_b7 <= 1'b0;
        end else if (ce && swr && apb_req.paddr == spvl_pkg::OFF_PMR) begin
            pmr_b7 <= apb_req.pwdata[7];
        end
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            sec_map <= '0;
        end else if (ce && swr && apb_req.paddr == spvl_pkg::OFF_SEC_CFG) begin
            sec_map <= apb_req.pwdata;
        end
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            rp7_h <= 3'h7;
            rpz_h <= 3'h0;
        end else if (ce) begin
            rp7_h <= {rp7_h[1:0], running_prio[7]};
            rpz_h <= {rpz_h[1:0], running_prio == 8'h00};
        end
    end
    a_pmr_ns_hidden: assert property (rd && ns && apb_req.paddr == spvl_pkg::OFF_PMR && !pmr_b7 |-> prdata == 0)
        else $error("mask register visible to non-secure read");
    a_rpr_ns_hidden: assert property (rd && ns && apb_req.paddr == spvl_pkg::OFF_RPR && rp7_h == 0 |-> prdata == 0)
        else $error("running priority visible to non-secure read");
    a_sec_field_raz: assert property (rd && ns && prio_hit && idx < NUM_IRQ && sec_map[idx[4:0]] |-> prdata == 0)
        else $error("secure field visible to non-secure read");
    a_ns_view_steps: assert property (rd && ns && prio_hit |-> (prdata & ~NS_OK) == 0)
        else $error("non-secure priority view has low bits set");
    a_s_unimpl_bits: assert property (rd && !ns && prio_hit |-> (prdata & ~S_OK) == 0)
        else $error("unimplemented priority bits read as one");
    a_ns_secure_only: assert property (pready && ns && (apb_req.paddr == spvl_pkg::OFF_BPR_ALIAS ||
        apb_req.paddr == spvl_pkg::OFF_SEC_CFG) |-> pslverr)
        else $error("secure-only register reached by non-secure access");
    a_zero_never_beaten: assert property (rpz_h == 3'h7 |-> !preempt_req)
        else $error("preemption of the highest running priority");
    a_preempt_cause: assert property (preempt_req |-> $past(cand_valid) && $past(cand_id) < NUM_IRQ)
        else $error("preemption without a valid candidate");
    c_preempt: cover property (preempt_req);
    c_ns_refused: cover property (pready && pslverr && ns);
    c_pmr_hidden: cover property (rd && ns && apb_req.paddr == spvl_pkg::OFF_PMR && !pmr_b7);
endmodule

bind spvl_top spvl_top_checker #(.NUM_IRQ(NUM_IRQ), .PRIO_BITS(PRIO_BITS)) chk (.clock(clock), .rst(rst), .ce(ce),
    .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cand_valid(cand_valid),
    .cand_id(cand_id), .running_prio(running_prio), .preempt_req(preempt_req));

/* File: tb/spvl_core_model.sv */
`timescale 1ns/100ps
module spvl_core_model (
    input wire logic clock,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    output spvl_pkg::spvl_apb_req_t apb_req
);
    initial apb_req = '0;
    task automatic xfer(input logic wr, input logic ns, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        @(posedge clock);
        apb_req <= '{1'b1, 1'b0, wr, {1'b0, ns, 1'b0}, a, d};
        @(posedge clock);
        apb_req.penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        // Released lines show the inverse so a stale value cannot pass.
        apb_req <= '{1'b0, 1'b0, ~wr, {1'b1, ~ns, 1'b1}, ~a, ~d};
    endtask
endmodule

/* File: tb/spvl_top_tb.sv */
`timescale 1ns/100ps
module spvl_top_tb;
    logic clock;
    logic rst;
    logic ce;
    logic cand_valid;
    logic [7:0] cand_id;
    logic [7:0] running_prio;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic preempt_req;
    logic [31:0] rd;
    logic err;
    int fails;
    int n_checks;
    int cycles = 0;
    spvl_pkg::spvl_apb_req_t apb_req;
    spvl_top #(.NUM_IRQ(32), .PRIO_BITS(7), .MIN_BP(1)) dut (.clock(clock), .rst(rst), .ce(ce),
        .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cand_valid(cand_valid),
        .cand_id(cand_id), .running_prio(running_prio), .preempt_req(preempt_req));
    spvl_core_model core (.clock(clock), .pready(pready), .prdata(prdata), .pslverr(pslverr), .apb_req(apb_req));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic wr(input logic ns, input logic [11:0] a, input logic [31:0] d);
        core.xfer(1'b1, ns, a, d, rd, err);
    endtask
    task automatic rc(input logic ns, input logic [11:0] a, input logic [31:0] e);
        core.xfer(1'b0, ns, a, 32'h0, rd, err);
        check(rd, e);
    endtask
    task automatic set_in(input logic [7:0] id, input logic [7:0] rp);
        @(posedge clock);
        cand_valid <= 1'b1;
        cand_id <= id;
        running_prio <= rp;
        repeat (3) @(posedge clock);
        @(negedge clock);
    endtask
    function automatic logic [11:0] pa(input int i);
        return spvl_pkg::OFF_PRIO_BASE + 12'(4 * i);
    endfunction
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles > 4000) begin
            fails++;
            wrap_up();
        end
    end
    initial begin
        rst = 1'b1;
        cand_valid = 1'b0;
        cand_id = 8'h00;
        running_prio = 8'hFF;
        fails = 0;
        n_checks = 0;
        ce = 1'b1;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        rc(0, spvl_pkg::OFF_PMR, 32'h0);
        rc(0, spvl_pkg::OFF_BPR, 32'h2);
        rc(1, spvl_pkg::OFF_BPR, 32'h3);
        rc(0, spvl_pkg::OFF_SEC_CFG, 32'h0);
        rc(0, pa(1), 32'h0);
        $display("reset test done");
        // Irq 1 has no candidate pending while its range is probed.
        wr(0, pa(1), 32'hFF);
        rc(0, pa(1), 32'hFE);
        rc(1, pa(1), 32'hFC);
        wr(0, pa(2), 32'h2A);
        rc(1, pa(2), 32'h54);
        wr(1, pa(2), 32'h64);
        rc(0, pa(2), 32'hB2);
        wr(1, pa(2), 32'h65);
        rc(1, pa(2), 32'h64);
        $display("view test done");
        wr(0, spvl_pkg::OFF_SEC_CFG, 32'h18);
        wr(0, pa(3), 32'h40);
        rc(1, pa(3), 32'h0);
        wr(1, pa(3), 32'hFF);
        rc(0, pa(3), 32'h40);
        core.xfer(1'b0, 1'b1, spvl_pkg::OFF_SEC_CFG, 32'h0, rd, err);
        check({31'h0, err}, 32'h1);
        core.xfer(1'b0, 1'b0, 12'h200, 32'h0, rd, err);
        check({31'h0, err}, 32'h1);
        $display("security test done");
        wr(0, spvl_pkg::OFF_PMR, 32'h40);
        rc(1, spvl_pkg::OFF_PMR, 32'h0);
        wr(1, spvl_pkg::OFF_PMR, 32'hFF);
        rc(0, spvl_pkg::OFF_PMR, 32'h40);
        cand_valid <= 1'b0;
        running_prio <= 8'h20;
        repeat (3) @(posedge clock);
        rc(1, spvl_pkg::OFF_RPR, 32'h0);
        running_prio <= 8'hA0;
        repeat (3) @(posedge clock);
        rc(1, spvl_pkg::OFF_RPR, 32'h40);
        rc(0, spvl_pkg::OFF_RPR, 32'hA0);
        $display("mask test done");
        wr(0, spvl_pkg::OFF_PMR, 32'hF0);
        wr(0, pa(4), 32'h80);
        wr(0, spvl_pkg::OFF_BPR, 32'h0);
        set_in(8'd4, 8'h82);
        check({31'h0, preempt_req}, 32'h0);
        set_in(8'd4, 8'h84);
        check({31'h0, preempt_req}, 32'h1);
        set_in(8'd4, 8'h7C);
        check({31'h0, preempt_req}, 32'h0);
        wr(0, pa(5), 32'h80);
        wr(0, spvl_pkg::OFF_BPR_ALIAS, 32'h4);
        set_in(8'd5, 8'h90);
        check({31'h0, preempt_req}, 32'h1);
        set_in(8'd5, 8'h84);
        check({31'h0, preempt_req}, 32'h0);
        wr(0, spvl_pkg::OFF_CTRL, 32'h1);
        set_in(8'd5, 8'h84);
        check({31'h0, preempt_req}, 32'h1);
        // With the enable low the request must hold although the running priority drops to zero.
        @(posedge clock);
        ce <= 1'b0;
        running_prio <= 8'h00;
        repeat (3) @(negedge clock);
        check({31'h0, preempt_req}, 32'h1);
        @(posedge clock);
        ce <= 1'b1;
        repeat (3) @(negedge clock);
        check({31'h0, preempt_req}, 32'h0);
        set_in(8'd40, 8'h84);
        check({31'h0, preempt_req}, 32'h0);
        $display("preemption test done");
        wrap_up();
    end
endmodule
